// ### verilog/sense_regs_pkg.sv
// Constants for the sense configuration and result register bank.
// Assumes a byte-wide register port driven by a two-wire bus front end.
package sense_regs_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CH1_SENSE_CFG_ADDR = 8'h0b;
  localparam logic [7:0] CH2_SENSE_CFG_ADDR = 8'h0c;
  localparam logic [7:0] CH1_SENSE_RES_HI_ADDR = 8'h0d;
  localparam logic [7:0] CH1_SENSE_RES_LO_ADDR = 8'h0e;
  localparam logic [7:0] CH2_SENSE_RES_HI_ADDR = 8'h0f;
  localparam logic [7:0] CH2_SENSE_RES_LO_ADDR = 8'h10;
  localparam logic [7:0] CH1_SOURCE_RES_HI_ADDR = 8'h11;
  localparam logic [7:0] CH1_SOURCE_RES_LO_ADDR = 8'h12;
  localparam logic [7:0] CH2_SOURCE_RES_HI_ADDR = 8'h13;
  localparam logic [7:0] CH2_SOURCE_RES_LO_ADDR = 8'h14;
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int SAMPLE_TIME_LSB = 4;
  localparam int SAMPLE_TIME_W = 3;
  localparam int AVERAGE_LSB = 2;
  localparam int AVERAGE_W = 2;
  localparam int RANGE_LSB = 0;
  localparam int RANGE_W = 2;
  localparam int CFG_USED_W = 7;
  localparam logic [6:0] SENSE_CFG_RESET = 7'h53;
  localparam int SENSE_RES_W = 12;
  localparam int SOURCE_RES_W = 11;
  localparam int SENSE_PAD_W = 4;
  localparam int SOURCE_PAD_W = 5;
  // Source code weights in microvolts: top bit and one step.
  localparam int SOURCE_TOP_UV = 20000000;
  localparam int SOURCE_STEP_UV = 19531;
endpackage

// ### verilog/sense_result_hold.sv
// Holds one channel's latest sense and source results.
// Assumes conversion results arrive as one-cycle strobes on sys_clk.
`timescale 1ns/10ps
module sense_result_hold
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic sense_valid,
  input wire logic [11:0] shunt_voltage,
  input wire logic source_valid,
  input wire logic [10:0] supply_side_voltage,
  output logic [15:0] sense_word,
  output logic [15:0] source_word
);
  // ****************************************
  // Result capture
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst || !enable)
    begin
      sense_word <= 16'h0000;
    end
    else if (sense_valid)
    begin
      sense_word <= {shunt_voltage, {sense_regs_pkg::SENSE_PAD_W{1'b0}}};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !enable)
    begin
      source_word <= 16'h0000;
    end
    else if (source_valid)
    begin
      // Binary weighted code, one step of about 19.531 mV.
      source_word <= {supply_side_voltage, {sense_regs_pkg::SOURCE_PAD_W{1'b0}}};
    end
  end
endmodule

// ### verilog/sense_config_result_regs.sv
// Sense sampling configuration and result register bank, two channels, or channel 1 only with DUAL_CHANNEL cleared.
// Assumes a bus front end that presents byte reads and writes on sys_clk.
`timescale 1ns/10ps
module sense_config_result_regs
#(
  parameter bit DUAL_CHANNEL = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic ch1_sense_valid,
  input wire logic [11:0] ch1_shunt_voltage,
  input wire logic ch1_source_valid,
  input wire logic [10:0] ch1_supply_side_voltage,
  input wire logic ch2_sense_valid,
  input wire logic [11:0] ch2_shunt_voltage,
  input wire logic ch2_source_valid,
  input wire logic [10:0] ch2_supply_side_voltage,
  output logic [2:0] ch1_sense_sample_time,
  output logic [1:0] ch1_sense_average_count,
  output logic [1:0] ch1_sense_range_or_result,
  output logic [2:0] ch2_sense_sample_time,
  output logic [1:0] ch2_sense_average_count,
  output logic [1:0] ch2_sense_range_or_result
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [6:0] ch1_cfg_q;
  logic [6:0] ch2_cfg_q;
  logic [15:0] ch1_sense_word;
  logic [15:0] ch1_source_word;
  logic [15:0] ch2_sense_word;
  logic [15:0] ch2_source_word;
  logic [7:0] rdata_d;
  logic ch1_cfg_hit;
  logic ch2_cfg_hit;
  logic [7:0] ch1_cfg_rd;
  logic [7:0] ch2_cfg_rd;
  logic [2:0] ch1_time_d;
  logic [1:0] ch1_avg_d;
  logic [1:0] ch1_range_d;
  logic [2:0] ch2_time_d;
  logic [1:0] ch2_avg_d;
  logic [1:0] ch2_range_d;

  // ****************************************
  // Address decode
  // ****************************************
  assign ch1_cfg_hit = reg_wr && reg_addr == sense_regs_pkg::CH1_SENSE_CFG_ADDR;
  assign ch2_cfg_hit = reg_wr && reg_addr == sense_regs_pkg::CH2_SENSE_CFG_ADDR && DUAL_CHANNEL;

  // ****************************************
  // Field extraction
  // ****************************************
  assign ch1_time_d = ch1_cfg_q[sense_regs_pkg::SAMPLE_TIME_LSB +: sense_regs_pkg::SAMPLE_TIME_W];
  assign ch1_avg_d = ch1_cfg_q[sense_regs_pkg::AVERAGE_LSB +: sense_regs_pkg::AVERAGE_W];
  assign ch1_range_d = ch1_cfg_q[sense_regs_pkg::RANGE_LSB +: sense_regs_pkg::RANGE_W];
  assign ch2_time_d = ch2_cfg_q[sense_regs_pkg::SAMPLE_TIME_LSB +: sense_regs_pkg::SAMPLE_TIME_W];
  assign ch2_avg_d = ch2_cfg_q[sense_regs_pkg::AVERAGE_LSB +: sense_regs_pkg::AVERAGE_W];
  assign ch2_range_d = ch2_cfg_q[sense_regs_pkg::RANGE_LSB +: sense_regs_pkg::RANGE_W];
  assign ch1_cfg_rd = {1'b0, ch1_cfg_q};
  assign ch2_cfg_rd = {1'b0, ch2_cfg_q};

  // ****************************************
  // Configuration storage
  // ****************************************

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ch1_cfg_q <= sense_regs_pkg::SENSE_CFG_RESET;
    end
    else if (ch1_cfg_hit)
    begin
      ch1_cfg_q <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !DUAL_CHANNEL)
    begin
      ch2_cfg_q <= DUAL_CHANNEL ? sense_regs_pkg::SENSE_CFG_RESET : 7'h00;
    end
    else if (ch2_cfg_hit)
    begin
      ch2_cfg_q <= reg_wdata[6:0];
    end
  end

  // ****************************************
  // Field outputs
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ch1_sense_sample_time <= 3'h0;
      ch1_sense_average_count <= 2'h0;
      ch1_sense_range_or_result <= 2'h0;
    end
    else
    begin
      ch1_sense_sample_time <= ch1_time_d;
      ch1_sense_average_count <= ch1_avg_d;
      ch1_sense_range_or_result <= ch1_range_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ch2_sense_sample_time <= 3'h0;
      ch2_sense_average_count <= 2'h0;
      ch2_sense_range_or_result <= 2'h0;
    end
    else
    begin
      ch2_sense_sample_time <= ch2_time_d;
      ch2_sense_average_count <= ch2_avg_d;
      ch2_sense_range_or_result <= ch2_range_d;
    end
  end

  // ****************************************
  // Result holding
  // ****************************************
  sense_result_hold ch1_hold
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(1'b1),
    .sense_valid(ch1_sense_valid),
    .shunt_voltage(ch1_shunt_voltage),
    .source_valid(ch1_source_valid),
    .supply_side_voltage(ch1_supply_side_voltage),
    .sense_word(ch1_sense_word),
    .source_word(ch1_source_word)
  );

  sense_result_hold ch2_hold
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(DUAL_CHANNEL),
    .sense_valid(ch2_sense_valid),
    .shunt_voltage(ch2_shunt_voltage),
    .source_valid(ch2_source_valid),
    .supply_side_voltage(ch2_supply_side_voltage),
    .sense_word(ch2_sense_word),
    .source_word(ch2_source_word)
  );

  // ****************************************
  // Read path
  // ****************************************
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      sense_regs_pkg::CH1_SENSE_CFG_ADDR: rdata_d = ch1_cfg_rd;
      sense_regs_pkg::CH2_SENSE_CFG_ADDR: rdata_d = ch2_cfg_rd;
      sense_regs_pkg::CH1_SENSE_RES_HI_ADDR: rdata_d = ch1_sense_word[15:8];
      sense_regs_pkg::CH1_SENSE_RES_LO_ADDR: rdata_d = ch1_sense_word[7:0];
      sense_regs_pkg::CH2_SENSE_RES_HI_ADDR: rdata_d = ch2_sense_word[15:8];
      sense_regs_pkg::CH2_SENSE_RES_LO_ADDR: rdata_d = ch2_sense_word[7:0];
      sense_regs_pkg::CH1_SOURCE_RES_HI_ADDR: rdata_d = ch1_source_word[15:8];
      sense_regs_pkg::CH1_SOURCE_RES_LO_ADDR: rdata_d = ch1_source_word[7:0];
      sense_regs_pkg::CH2_SOURCE_RES_HI_ADDR: rdata_d = ch2_source_word[15:8];
      sense_regs_pkg::CH2_SOURCE_RES_LO_ADDR: rdata_d = ch2_source_word[7:0];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // ****************************************
  // Read valid
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
    end
  end
endmodule

// ### sim/sense_regs_asserts.sv
// Checker for the sense register bank, bound to its top module.
// Assumes reads answered one cycle later; holds for either channel build.
`timescale 1ns/10ps
module sense_regs_asserts
(
  input logic sys_clk,
  input logic rst,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic ch1_sense_valid,
  input logic [11:0] ch1_shunt_voltage,
  input logic [2:0] ch1_sense_sample_time,
  input logic [1:0] ch1_sense_average_count,
  input logic [1:0] ch1_sense_range_or_result
);
  logic cw;
  logic [7:0] ra;
  assign cw = reg_wr && reg_addr == 8'h0b;
  assign ra = reg_rd ? reg_addr : 8'hff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_time; cw |=> ##1 ch1_sense_sample_time == $past(reg_wdata[6:4], 2); endproperty
  a_time: assert property (p_time) else $error("sample time");
  property p_avg; cw |=> ##1 ch1_sense_average_count == $past(reg_wdata[3:2], 2); endproperty
  a_avg: assert property (p_avg) else $error("average");
  property p_rng; cw |=> ##1 ch1_sense_range_or_result == $past(reg_wdata[1:0], 2); endproperty
  a_rng: assert property (p_rng) else $error("range");
  property p_sense;
    ch1_sense_valid ##1 (ra == 8'h0d && !ch1_sense_valid)
      |=> reg_rdata == $past(ch1_shunt_voltage[11:4], 2);
  endproperty
  a_sense: assert property (p_sense) else $error("sense high byte");
  property p_pad; ra == 8'h0e |=> reg_rdata[3:0] == 4'h0; endproperty
  a_pad: assert property (p_pad) else $error("sense pad");
  property p_src; ra == 8'h12 |=> reg_rdata[4:0] == 5'h00; endproperty
  a_src: assert property (p_src) else $error("source pad");
  property p_src2; ra == 8'h14 |=> reg_rdata[4:0] == 5'h00; endproperty
  a_src2: assert property (p_src2) else $error("source two pad");
  property p_bit7; ra == 8'h0b || ra == 8'h0c |=> !reg_rdata[7]; endproperty
  a_bit7: assert property (p_bit7) else $error("config top bit");
endmodule
bind sense_config_result_regs sense_regs_asserts sense_regs_asserts_inst (.*);

// ### sim/conv_model.sv
// Converter stand-in: strobes all four results from one code.
// Assumes the bench pulses fire for one cycle at a time.
`timescale 1ns/10ps
module conv_model
(
  input logic sys_clk,
  input logic fire,
  input logic [11:0] code,
  output logic strobe = 1'b0,
  output logic [11:0] sense1 = 12'h000,
  output logic [11:0] sense2 = 12'h000,
  output logic [10:0] src1 = 11'h000,
  output logic [10:0] src2 = 11'h000
);
  // Outside a strobe the lines carry nothing valid, so they toggle.
  always @(posedge sys_clk)
  begin
    strobe <= fire;
    sense1 <= fire ? code : ~sense1;
    sense2 <= fire ? ~code : ~sense2;
    src1 <= fire ? code[10:0] ^ 11'h555 : ~src1;
    src2 <= fire ? code[11:1] : ~src2;
  end
endmodule

// ### sim/sense_config_result_regs_tb.sv
// Self-checking bench for the sense register bank.
// Runs the two-channel and single-channel builds side by side on the converter stand-in.
`timescale 1ns/10ps
module sense_config_result_regs_tb;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0, rv, st;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdat;
  logic [11:0] code = 12'h000, s1, s2;
  logic [10:0] v1, v2;
  wire [6:0] f1, f2, g1, g2;
  logic [7:0] rdat2;
  logic rv2;
  logic [15:0] w [4] = '{4{16'h0000}};
  int err_total = 0, comparisons = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  conv_model conv_model_inst (.sys_clk, .fire, .code, .strobe(st), .sense1(s1), .sense2(s2),
    .src1(v1), .src2(v2));
  sense_config_result_regs sense_config_result_regs_inst (.sys_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata(rdat), .reg_rvalid(rv), .ch1_sense_valid(st),
    .ch1_shunt_voltage(s1), .ch1_source_valid(st), .ch1_supply_side_voltage(v1),
    .ch2_sense_valid(st), .ch2_shunt_voltage(s2), .ch2_source_valid(st),
    .ch2_supply_side_voltage(v2), .ch1_sense_sample_time(f1[6:4]),
    .ch1_sense_average_count(f1[3:2]), .ch1_sense_range_or_result(f1[1:0]),
    .ch2_sense_sample_time(f2[6:4]), .ch2_sense_average_count(f2[3:2]),
    .ch2_sense_range_or_result(f2[1:0]));
  sense_config_result_regs #(.DUAL_CHANNEL(1'b0)) single_sense_config_result_regs_inst (.sys_clk,
    .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(rdat2), .reg_rvalid(rv2),
    .ch1_sense_valid(st), .ch1_shunt_voltage(s1), .ch1_source_valid(st),
    .ch1_supply_side_voltage(v1), .ch2_sense_valid(st), .ch2_shunt_voltage(s2),
    .ch2_source_valid(st), .ch2_supply_side_voltage(v2), .ch1_sense_sample_time(g1[6:4]),
    .ch1_sense_average_count(g1[3:2]), .ch1_sense_range_or_result(g1[1:0]),
    .ch2_sense_sample_time(g2[6:4]), .ch2_sense_average_count(g2[3:2]),
    .ch2_sense_range_or_result(g2[1:0]));
  task check(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    logic [7:0] e_single;
    e_single = (a == 8'h0c || a == 8'h0f || a == 8'h10 || a >= 8'h13) ? 8'h00 : e;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check($sformatf("read %h", a), {7'h00, rv, rdat}, {8'h01, e});
    check($sformatf("single %h", a), {7'h00, rv2, rdat2}, {8'h01, e_single});
    @(posedge sys_clk);
  endtask
  task conv(logic [11:0] c);
    code <= c;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    @(posedge sys_clk);
    w[0] = {c, 4'h0};
    w[1] = {~c, 4'h0};
    w[2] = {c[10:0] ^ 11'h555, 5'h00};
    w[3] = {c[11:1], 5'h00};
  endtask
  task results();
    for (int j = 0; j < 4; j++)
    begin
      rd(8'h0d + 8'(2 * j), w[j][15:8]);
      rd(8'h0e + 8'(2 * j), w[j][7:0]);
    end
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h0b, 8'h53);
    rd(8'h0c, 8'h53);
    rd(8'h30, 8'h00);
    check("fields", {2'b00, f1, f2}, {2'b00, 7'h53, 7'h53});
    check("single fields", {2'b00, g1, g2}, {2'b00, 7'h53, 7'h00});
    results();
    $display("test reset done");
    wr(8'h0b, 8'hff);
    wr(8'h0c, 8'ha5);
    rd(8'h0b, 8'h7f);
    rd(8'h0c, 8'h25);
    check("fields", {2'b00, f1, f2}, {2'b00, 7'h7f, 7'h25});
    check("single fields", {2'b00, g1, g2}, {2'b00, 7'h7f, 7'h00});
    $display("test config done");
    conv(12'habc);
    results();
    conv(12'hfff);
    results();
    for (int i = 0; i < 8; i++)
      wr(8'h0d + 8'(i), 8'h5a);
    results();
    $display("test results done");
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    w = '{4{16'h0000}};
    rd(8'h0b, 8'h53);
    rd(8'h0c, 8'h53);
    check("fields", {2'b00, f1, f2}, {2'b00, 7'h53, 7'h53});
    results();
    $display("test second reset done");
    conclude();
  end
endmodule
